// File: rtl/vfws_pkg.sv
package vfws_pkg;

  // Command codes on the management port
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OV_RESPONSE = 8'h56;
  localparam logic [7:0] CMD_OV_WARN_LIMIT = 8'h57;
  localparam logic [7:0] CMD_UV_WARN_LIMIT = 8'h58;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_INPUT = 8'h7C;

  // Reset values
  localparam logic [7:0] OV_RESPONSE_RST = 8'h80;
  localparam logic [15:0] OV_WARN_LIMIT_RST = 16'hD360;
  localparam logic [7:0] PAGE_RST = 8'h00;

  // Response register fields
  localparam int RESP_MODE_HI = 7;
  localparam int RESP_MODE_LO = 6;
  localparam int RESP_RETRY_HI = 5;
  localparam int RESP_RETRY_LO = 3;
  localparam logic [7:0] RESP_WR_MASK = 8'hF8;
  localparam logic [1:0] MODE_RETRY = 2'h2;
  localparam logic [1:0] MODE_WHILE = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Linear-11 fields
  localparam int LIN_EXP_HI = 15;
  localparam int LIN_EXP_LO = 11;
  localparam int LIN_SIGN = 10;
  localparam int LIN_MAG_HI = 9;
  localparam int LIN_MAG_W = 10;

  // Fixed-point voltage: unsigned, FIX_FRAC fractional bits
  localparam int FIX_W = 24;
  localparam logic signed [5:0] FIX_FRAC = 6'sh08;

  // Warning default scale: 1.03 approximated by 1055/1024
  localparam logic [10:0] UV_SCALE_NUM = 11'h41F;
  localparam int UV_SCALE_SHIFT = 10;

  // Status bit positions
  localparam int SW_NONE_OF_ABOVE = 0;
  localparam int SW_VIN_UV = 3;
  localparam int SW_INPUT = 13;
  localparam int SI_OV_FAULT = 7;
  localparam int SI_OV_WARN = 6;
  localparam int SI_UV_WARN = 5;
  localparam int SI_UV_FAULT = 4;

  // Retry spacing
  localparam longint CLK_PERIOD_NS = 10;
  localparam longint RETRY_TIME_NS = 70000000;
  localparam int RETRY_CYCLES_DEF = int'(RETRY_TIME_NS / CLK_PERIOD_NS);

  // Per-page fault handling states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_LATCHED,
    ST_RETRY_WAIT,
    ST_OFF_WHILE
  } vfws_state_t;

  // Command from the protocol layer
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } vfws_cmd_t;

  // Answer to a read or write
  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] rdata;
  } vfws_rsp_t;

endpackage

// File: rtl/vfws_supervisor.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Response mode 10 disables output on fault, then retries only if retry field is 111.
// - Response mode 11 keeps output off only while the fault persists.
// - Overvoltage fault drives alert_out_n low; response modes 00 and 01 unused.
// - Fault status bits are sticky; only the clear-faults command clears them.
// - Retry field 000 keeps output off until the fault is cleared.
// - Retry field 111 restarts endlessly until commanded off, bias lost, other fault.
// - Successive restart attempts are spaced by one 70 ms retry time.
// - Response register is one byte, bits 2:0 unused, resets to 80h.
// - Overvoltage warning sets summary, input and warning bits and alerts host.
// - Undervoltage warning sets summary, input and warning bits and alerts host.
// - Undervoltage fault holds until input rises above the undervoltage warning limit.
// - Warning limits are two-byte Linear-11 values, mantissa times two to exponent.
// - Overvoltage warning limit resets to D360h, which is 13.5 V.
// - Undervoltage warning default is 1.03 times strapped fault limit, computed at startup.
// - Each setting has a copy per page, selected by the addressed page.
// - Overvoltage fault when measured input exceeds the overvoltage fault threshold.
module vfws_supervisor #(
  parameter int NUM_PAGES = 2,
  parameter int RETRY_CYCLES = vfws_pkg::RETRY_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire vfws_pkg::vfws_cmd_t cmd,
  output vfws_pkg::vfws_rsp_t rsp,
  input wire logic vin_sample_valid,
  input wire logic [vfws_pkg::FIX_W-1:0] vin_sample,
  input wire logic [15:0] ov_fault_limit,
  input wire logic [15:0] uv_fault_limit_strap,
  input wire logic control_pin,
  input wire logic bias_ok_pin,
  input wire logic [NUM_PAGES-1:0] operation_on,
  input wire logic [NUM_PAGES-1:0] other_fault,
  output logic [NUM_PAGES-1:0] output_enable,
  output logic alert_out_n
);
  import vfws_pkg::*;

  localparam int CNT_W = $clog2(RETRY_CYCLES + 1);
  localparam logic [CNT_W-1:0] RETRY_LAST = CNT_W'(RETRY_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Linear-11 to unsigned fixed point; negative values read as zero
  function automatic logic [FIX_W-1:0] lin11_to_fix(input logic [15:0] v);
    logic signed [5:0] sh;
    logic [FIX_W-1:0] mag;
    logic [FIX_W-1:0] res;
    sh = signed'({v[LIN_EXP_HI], v[LIN_EXP_HI:LIN_EXP_LO]}) + FIX_FRAC;
    mag = {{(FIX_W-LIN_MAG_W){1'b0}}, v[LIN_MAG_HI:0]};
    if (v[LIN_SIGN]) begin
      res = '0;
    end else if (sh >= 0) begin
      res = mag << sh;
    end else begin
      res = mag >> 6'(-sh);
    end
    return res;
  endfunction

  // Page number to array index, out-of-range pages fold onto page 0
  function automatic int page_idx(input logic [7:0] pg);
    int idx;
    idx = 0;
    if (int'(pg) < NUM_PAGES) begin
      idx = int'(pg);
    end
    return idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic ctrl_meta_q;
  logic ctrl_sync_q;
  logic bias_meta_q;
  logic bias_sync_q;

  // Two flops on each asynchronous pin
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_meta_q <= 1'b0;
      ctrl_sync_q <= 1'b0;
      bias_meta_q <= 1'b0;
      bias_sync_q <= 1'b0;
    end else begin
      ctrl_meta_q <= control_pin;
      ctrl_sync_q <= ctrl_meta_q;
      bias_meta_q <= bias_ok_pin;
      bias_sync_q <= bias_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode and paged configuration

  logic [7:0] page_q;
  logic [7:0] resp_q [NUM_PAGES];
  logic [15:0] ovw_q [NUM_PAGES];
  logic [15:0] uvw_q [NUM_PAGES];
  logic uvw_pending_q;
  logic [15:0] uvw_default;
  logic [20:0] uv_prod;
  logic [15:0] status_word [NUM_PAGES];
  logic [7:0] status_input [NUM_PAGES];
  logic wr_en;
  logic clear_en;
  int cur;

  assign cur = page_idx(page_q);
  assign wr_en = cmd.valid && cmd.write;
  assign clear_en = wr_en && (cmd.code == CMD_CLEAR_FAULTS);

  // Default warning limit is 1.03 x strap, keeping the exponent unless the mantissa overflows
  assign uv_prod = 21'(uv_fault_limit_strap[LIN_MAG_HI:0]) * 21'(UV_SCALE_NUM);
  always_comb begin
    uvw_default = uv_fault_limit_strap;
    uvw_default[LIN_MAG_HI:0] = uv_prod[UV_SCALE_SHIFT +: LIN_MAG_W];
    if (uv_prod[UV_SCALE_SHIFT+LIN_MAG_W] != 1'b0) begin
      // Mantissa overflow: halve it and bump the exponent
      uvw_default[LIN_MAG_HI:0] = uv_prod[UV_SCALE_SHIFT+1 +: LIN_MAG_W];
      uvw_default[LIN_EXP_HI:LIN_EXP_LO] = uv_fault_limit_strap[LIN_EXP_HI:LIN_EXP_LO] + 5'h01;
    end
  end

  // Page pointer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      page_q <= PAGE_RST;
    end else if (wr_en && cmd.code == CMD_PAGE) begin
      page_q <= cmd.wdata[7:0];
    end
  end

  // Strap is taken on the first edge after reset release
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      uvw_pending_q <= 1'b1;
    end else begin
      uvw_pending_q <= 1'b0;
    end
  end

  // Per-page settings, written only for the addressed page
  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < NUM_PAGES; p++) begin
      if (reset) begin
        resp_q[p] <= OV_RESPONSE_RST;
        ovw_q[p] <= OV_WARN_LIMIT_RST;
        uvw_q[p] <= '0;
      end else if (uvw_pending_q) begin
        uvw_q[p] <= uvw_default;
      end else if (wr_en && p == cur) begin
        if (cmd.code == CMD_OV_RESPONSE) begin
          resp_q[p] <= cmd.wdata[7:0] & RESP_WR_MASK;
        end
        if (cmd.code == CMD_OV_WARN_LIMIT) begin
          ovw_q[p] <= cmd.wdata;
        end
        if (cmd.code == CMD_UV_WARN_LIMIT) begin
          uvw_q[p] <= cmd.wdata;
        end
      end
    end
  end

  // Answers: one cycle after the command, unknown codes flagged
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rsp <= '0;
    end else begin
      rsp.valid <= cmd.valid;
      rsp.err <= 1'b0;
      rsp.rdata <= '0;
      if (cmd.valid) begin
        case (cmd.code)
          CMD_PAGE: rsp.rdata <= {8'h00, page_q};
          CMD_CLEAR_FAULTS: rsp.err <= !cmd.write;
          CMD_OV_RESPONSE: rsp.rdata <= {8'h00, resp_q[cur]};
          CMD_OV_WARN_LIMIT: rsp.rdata <= ovw_q[cur];
          CMD_UV_WARN_LIMIT: rsp.rdata <= uvw_q[cur];
          CMD_STATUS_WORD: begin
            rsp.rdata <= status_word[cur];
            rsp.err <= cmd.write;
          end
          CMD_STATUS_INPUT: begin
            rsp.rdata <= {8'h00, status_input[cur]};
            rsp.err <= cmd.write;
          end
          default: rsp.err <= 1'b1;
        endcase
        // Writes answer with zero data, reads keep theirs
        if (cmd.write) begin
          rsp.rdata <= '0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-page detection, status and fault response

  logic [FIX_W-1:0] ov_fault_thr;
  logic [FIX_W-1:0] uv_fault_thr;

  assign ov_fault_thr = lin11_to_fix(ov_fault_limit);
  assign uv_fault_thr = lin11_to_fix(uv_fault_limit_strap);

  logic [NUM_PAGES-1:0] page_alert;

  genvar g;
  generate
    for (g = 0; g < NUM_PAGES; g++) begin : g_page
      vfws_state_t state_q;
      logic [CNT_W-1:0] retry_cnt_q;
      logic ov_fault;
      logic ov_warn;
      logic uv_warn;
      logic uv_below;
      logic uv_above_warn;
      logic uv_fault_q;
      logic st_ov_fault_q;
      logic st_ov_warn_q;
      logic st_uv_warn_q;
      logic st_uv_fault_q;
      logic clr;
      logic stop_retry;
      logic [1:0] mode;
      logic [2:0] retry;

      assign mode = resp_q[g][RESP_MODE_HI:RESP_MODE_LO];
      assign retry = resp_q[g][RESP_RETRY_HI:RESP_RETRY_LO];
      assign clr = clear_en && (cur == g);

      // Compare each fresh sample against the shared fault limits and this page's warning limits
      assign ov_fault = vin_sample_valid && (vin_sample > ov_fault_thr);
      assign ov_warn = vin_sample_valid && (vin_sample > lin11_to_fix(ovw_q[g]));
      assign uv_warn = vin_sample_valid && (vin_sample < lin11_to_fix(uvw_q[g]));
      assign uv_below = vin_sample_valid && (vin_sample < uv_fault_thr);
      assign uv_above_warn = vin_sample_valid && (vin_sample > lin11_to_fix(uvw_q[g]));
      assign stop_retry = !ctrl_sync_q || !operation_on[g] || !bias_sync_q || other_fault[g];

      // Undervoltage fault condition with warning-limit hysteresis
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          uv_fault_q <= 1'b0;
        end else if (uv_below) begin
          uv_fault_q <= 1'b1;
        end else if (uv_above_warn) begin
          uv_fault_q <= 1'b0;
        end
      end

      // Sticky status bits; a new event beats a clear in the same cycle
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          st_ov_fault_q <= 1'b0;
          st_ov_warn_q <= 1'b0;
          st_uv_warn_q <= 1'b0;
          st_uv_fault_q <= 1'b0;
        end else begin
          st_ov_fault_q <= ov_fault || (st_ov_fault_q && !clr);
          st_ov_warn_q <= ov_warn || (st_ov_warn_q && !clr);
          st_uv_warn_q <= uv_warn || (st_uv_warn_q && !clr);
          st_uv_fault_q <= uv_fault_q || (st_uv_fault_q && !clr);
        end
      end

      // Status views: summary and input bits follow any input event
      always_comb begin
        status_input[g] = '0;
        status_input[g][SI_OV_FAULT] = st_ov_fault_q;
        status_input[g][SI_OV_WARN] = st_ov_warn_q;
        status_input[g][SI_UV_WARN] = st_uv_warn_q;
        status_input[g][SI_UV_FAULT] = st_uv_fault_q;
        status_word[g] = '0;
        status_word[g][SW_INPUT] = |status_input[g];
        status_word[g][SW_NONE_OF_ABOVE] = |status_input[g];
        status_word[g][SW_VIN_UV] = st_uv_fault_q;
      end
      assign page_alert[g] = |status_input[g];

      // Fault response state machine
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          state_q <= ST_RUN;
        end else begin
          case (state_q)
            ST_RUN: begin
              if (ov_fault) begin
                if (mode == MODE_WHILE) begin
                  state_q <= ST_OFF_WHILE;
                end else if (mode == MODE_RETRY && retry == RETRY_FOREVER) begin
                  state_q <= ST_RETRY_WAIT;
                end else begin
                  // Unused codes act as shutdown without retry
                  state_q <= ST_LATCHED;
                end
              end
            end
            ST_LATCHED: begin
              if (clr) begin
                state_q <= ST_RUN;
              end
            end
            ST_RETRY_WAIT: begin
              if (stop_retry) begin
                state_q <= ST_LATCHED;
              end else if (retry_cnt_q == RETRY_LAST) begin
                state_q <= ST_RUN;
              end
            end
            ST_OFF_WHILE: begin
              if (vin_sample_valid && !(vin_sample > ov_fault_thr)) begin
                state_q <= ST_RUN;
              end
            end
            default: state_q <= ST_RUN;
          endcase
        end
      end

      // Retry spacing counter
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          retry_cnt_q <= '0;
        end else if (state_q == ST_RETRY_WAIT && retry_cnt_q != RETRY_LAST) begin
          retry_cnt_q <= retry_cnt_q + 1'b1;
        end else begin
          retry_cnt_q <= '0;
        end
      end

      // Output enable, registered
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          output_enable[g] <= 1'b0;
        end else begin
          output_enable[g] <= (state_q == ST_RUN) && !ov_fault && !stop_retry;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Alert line: low while any page holds a status bit

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      alert_out_n <= 1'b1;
    end else begin
      alert_out_n <= !(|page_alert);
    end
  end

endmodule

// File: test/vfws_host_model.sv
`timescale 1ns/1ps
// Management host: one strobed command per call, expected answer queued
module vfws_host_model (
  input wire logic sys_clk,
  output vfws_pkg::vfws_cmd_t cmd
);
  import vfws_pkg::*;
  logic [16:0] exp_q[$];

  initial cmd = '0;

  ////////////////////////////////////////
  // Strobe for one edge; idle fields show inverted junk, not stale data
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      input logic [16:0] e);
    @(negedge sys_clk);
    cmd <= {1'b1, w, c, d};
    exp_q.push_back(e);
    @(negedge sys_clk);
    cmd <= {1'b0, ~w, ~c, ~d};
  endtask
endmodule

// File: test/vfws_supervisor_asserts.sv
`timescale 1ns/1ps
// Port-level checks for the input supervisor
module vfws_supervisor_asserts #(
  parameter int NUM_PAGES = 2,
  parameter int RETRY_CYCLES = vfws_pkg::RETRY_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire vfws_pkg::vfws_cmd_t cmd,
  input wire vfws_pkg::vfws_rsp_t rsp,
  input wire logic vin_sample_valid,
  input wire logic [vfws_pkg::FIX_W-1:0] vin_sample,
  input wire logic [15:0] ov_fault_limit,
  input wire logic [15:0] uv_fault_limit_strap,
  input wire logic control_pin,
  input wire logic bias_ok_pin,
  input wire logic [NUM_PAGES-1:0] operation_on,
  input wire logic [NUM_PAGES-1:0] other_fault,
  input wire logic [NUM_PAGES-1:0] output_enable,
  input wire logic alert_out_n
);
  import vfws_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic clr_cmd;

  ////////////////////////////////////////
  // Clear-faults command decode
  assign clr_cmd = cmd.valid && cmd.write && (cmd.code == CMD_CLEAR_FAULTS);

  ////////////////////////////////////////
  rsp_timing_a: assert property (
    rsp.valid == $past(cmd.valid)) else $error("answer not one cycle after command");
  resp_field_a: assert property (
    rsp.valid && !$past(cmd.write) && $past(cmd.code) == CMD_OV_RESPONSE
    |-> rsp.rdata[2:0] == 3'h0 && rsp.rdata[15:8] == 8'h00) else $error("response bits");
  status_ro_a: assert property (
    cmd.valid && cmd.write && (cmd.code == CMD_STATUS_WORD || cmd.code == CMD_STATUS_INPUT)
    |=> rsp.err) else $error("status write not refused");
  alert_trip_a: assert property (
    $fell(output_enable[0]) && $past(vin_sample_valid) && operation_on[0] && control_pin
    && bias_ok_pin |=> !alert_out_n) else $error("no alert on fault trip");
  clear_only_a: assert property (
    $rose(alert_out_n) |-> $past(clr_cmd, 2) || $past(clr_cmd, 3))
    else $error("alert released without clear");
  ctrl_off_a: assert property (
    !control_pin [*4] |-> output_enable == '0) else $error("on while control off");
  bias_off_a: assert property (
    !bias_ok_pin [*4] |-> output_enable == '0) else $error("on without bias");
  op_off_a: assert property (
    !operation_on[0] [*2] |-> !output_enable[0]) else $error("on while commanded off");
endmodule

bind vfws_supervisor vfws_supervisor_asserts #(.NUM_PAGES(NUM_PAGES),
  .RETRY_CYCLES(RETRY_CYCLES)) chk_i (.sys_clk(sys_clk), .reset(reset), .cmd(cmd),
  .rsp(rsp), .vin_sample_valid(vin_sample_valid), .vin_sample(vin_sample),
  .ov_fault_limit(ov_fault_limit), .uv_fault_limit_strap(uv_fault_limit_strap),
  .control_pin(control_pin), .bias_ok_pin(bias_ok_pin), .operation_on(operation_on),
  .other_fault(other_fault), .output_enable(output_enable), .alert_out_n(alert_out_n));

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
  import vfws_pkg::*;
  localparam int RETRY = 8;
  logic sys_clk;
  logic reset;
  vfws_cmd_t cmd;
  vfws_rsp_t rsp;
  logic vin_sample_valid;
  logic [FIX_W-1:0] vin_sample;
  logic [2:0] stop_v;
  logic oth;
  logic [1:0] output_enable;
  logic alert_out_n;
  logic [16:0] exp_v;
  int failures;
  int checks_done;
  int cycles;
  int seed;
  int n;
  logic [31:0] r;
  logic [7:0] codes [5] = '{8'h80, 8'h00, 8'h40, 8'h88, 8'hB0};
  logic [39:0] warn_t [2] = '{{24'h000DC0, 16'h0040}, {24'h000490, 16'h0020}};

  ////////////////////////////////////////
  // Device under test and its host
  vfws_supervisor #(.NUM_PAGES(2), .RETRY_CYCLES(RETRY)) vfws_supervisor_i (
    .sys_clk(sys_clk), .reset(reset), .cmd(cmd), .rsp(rsp),
    .vin_sample_valid(vin_sample_valid), .vin_sample(vin_sample),
    .ov_fault_limit(16'hD380), .uv_fault_limit_strap(16'hD120),
    .control_pin(!stop_v[0]), .bias_ok_pin(!stop_v[1]), .operation_on({1'b1, !stop_v[2]}),
    .other_fault({1'b0, oth}), .output_enable(output_enable), .alert_out_n(alert_out_n));
  vfws_host_model vfws_host_model_i (.sys_clk(sys_clk), .cmd(cmd));

  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////
  task automatic check_rsp(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_lvl(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    // Answers still owed count against the run
    failures += vfws_host_model_i.exp_q.size();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    vfws_host_model_i.xfer(1'b1, c, d, 17'h00000);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    vfws_host_model_i.xfer(1'b0, c, 16'h0000, {1'b0, e});
  endtask
  task automatic smp(input logic [23:0] v);
    @(negedge sys_clk);
    vin_sample <= v;
    vin_sample_valid <= 1'b1;
    @(negedge sys_clk);
    vin_sample_valid <= 1'b0;
  endtask
  task automatic clr();
    for (int p = 1; p >= 0; p--) begin
      wr(CMD_PAGE, 16'(p));
      wr(CMD_CLEAR_FAULTS, 16'h0000);
    end
  endtask
  task automatic wait_en(input logic v, input int lim);
    for (int i = 0; i < lim && output_enable[0] !== v; i++) @(negedge sys_clk);
    check_lvl(output_enable[0], v);
  endtask

  ////////////////////////////////////////
  // Answer watcher: oldest note against each answer, mid-cycle when settled
  always @(negedge sys_clk) begin
    if (rsp.valid === 1'b1) begin
      exp_v = (vfws_host_model_i.exp_q.size() > 0) ? vfws_host_model_i.exp_q.pop_front()
                                                  : 17'h1FFFF;
      check_rsp({rsp.err, rsp.rdata}, exp_v);
    end
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end

  ////////////////////////////////////////
  // Main sequence
  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    vin_sample_valid = 1'b0;
    vin_sample = 24'h000C00;
    stop_v = 3'h0;
    oth = 1'b0;
    seed = 32'h2A1B2B91;
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    rd(CMD_OV_RESPONSE, 16'h0080);
    rd(CMD_OV_WARN_LIMIT, 16'hD360);
    rd(CMD_UV_WARN_LIMIT, 16'hD128);
    rd(CMD_STATUS_INPUT, 16'h0000);
    check_lvl(alert_out_n, 1'b1);
    check_lvl(output_enable[1], 1'b1);
    $display("test reset_values done");
    for (int i = 0; i < 2; i++) begin
      smp(warn_t[i][39:16]);
      rd(CMD_STATUS_INPUT, warn_t[i][15:0]);
      rd(CMD_STATUS_WORD, 16'h2001);
      check_lvl(alert_out_n, 1'b0);
      clr();
      repeat (4) @(negedge sys_clk);
      check_lvl(alert_out_n, 1'b1);
    end
    $display("test warnings done");
    // Undervoltage fault holds between fault and warning limits
    smp(24'h000400);
    smp(24'h000490);
    clr();
    rd(CMD_STATUS_INPUT, 16'h0010);
    rd(CMD_STATUS_WORD, 16'h2009);
    check_lvl(alert_out_n, 1'b0);
    smp(24'h000C00);
    clr();
    rd(CMD_STATUS_INPUT, 16'h0000);
    repeat (4) @(negedge sys_clk);
    check_lvl(alert_out_n, 1'b1);
    $display("test uv_hysteresis done");
    for (int i = 0; i < 5; i++) begin
      wr(CMD_OV_RESPONSE, {8'h00, codes[i]});
      smp(24'h000F00);
      wait_en(1'b0, 4);
      rd(CMD_STATUS_INPUT, 16'h00C0);
      smp(24'h000C00);
      repeat (RETRY + 4) @(negedge sys_clk);
      check_lvl(output_enable[0], 1'b0);
      check_lvl(alert_out_n, 1'b0);
      clr();
      wait_en(1'b1, 6);
    end
    $display("test latched_codes done");
    wr(CMD_OV_RESPONSE, 16'h00C0);
    smp(24'h000F00);
    wait_en(1'b0, 4);
    smp(24'h000C00);
    wait_en(1'b1, 6);
    rd(CMD_STATUS_INPUT, 16'h00C0);
    clr();
    $display("test while_present done");
    wr(CMD_OV_RESPONSE, 16'h00B8);
    smp(24'h000F00);
    wait_en(1'b0, 2);
    for (n = 0; n < 40 && output_enable[0] !== 1'b1; n++) @(negedge sys_clk);
    check_lvl(n >= RETRY - 2 && n <= RETRY + 1, 1'b1);
    smp(24'h000F00);
    wait_en(1'b0, 4);
    oth <= 1'b1;
    repeat (3) @(negedge sys_clk);
    oth <= 1'b0;
    repeat (RETRY + 6) @(negedge sys_clk);
    check_lvl(output_enable[0], 1'b0);
    clr();
    wait_en(1'b1, 8);
    $display("test retry done");
    for (int i = 0; i < 3; i++) begin
      stop_v <= 3'(1 << i);
      repeat (6) @(negedge sys_clk);
      check_lvl(output_enable[0], 1'b0);
      stop_v <= 3'h0;
      wait_en(1'b1, 8);
    end
    $display("test stop_inputs done");
    vfws_host_model_i.xfer(1'b1, CMD_STATUS_WORD, 16'h0000, 17'h10000);
    vfws_host_model_i.xfer(1'b0, CMD_CLEAR_FAULTS, 16'h0000, 17'h10000);
    vfws_host_model_i.xfer(1'b1, 8'h20, 16'h0000, 17'h10000);
    $display("test refusals done");
    for (int i = 0; i < 3; i++) begin
      wr(CMD_PAGE, 16'h0001);
      r = $random(seed);
      wr(CMD_OV_WARN_LIMIT, r[15:0]);
      wr(CMD_OV_RESPONSE, {8'h00, r[23:16]});
      rd(CMD_OV_WARN_LIMIT, r[15:0]);
      rd(CMD_OV_RESPONSE, {8'h00, r[23:16] & 8'hF8});
      wr(CMD_PAGE, 16'h0000);
      rd(CMD_OV_WARN_LIMIT, 16'hD360);
    end
    $display("test paged_random done");
    repeat (4) @(negedge sys_clk);
    close_out();
  end
endmodule
